/* hw/pfm_pkg.sv */
// Purpose: Shared constants and types of the pad function and mode block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   Field layout of the pin configuration word is chosen locally
package pfm_pkg;

    // Register byte offsets
    localparam logic [11:0] PFM_OFF_P2_6      = 12'h000; // Pin config
    localparam logic [11:0] PFM_OFF_RSVD_A    = 12'h004; // Reserved slot
    localparam logic [11:0] PFM_OFF_P2_0      = 12'h008; // Pin config
    localparam logic [11:0] PFM_OFF_RST_P0_0  = 12'h00c; // Pin config
    localparam logic [11:0] PFM_OFF_P0_1      = 12'h010; // Pin config
    localparam logic [11:0] PFM_OFF_P1_8      = 12'h014; // Pin config
    localparam logic [11:0] PFM_OFF_RSVD_B    = 12'h018; // Reserved slot
    localparam logic [11:0] PFM_OFF_P0_2      = 12'h01c; // Pin config
    localparam logic [11:0] PFM_OFF_P2_7      = 12'h020; // Pin config
    localparam logic [11:0] PFM_OFF_P2_8      = 12'h024; // Pin config
    localparam logic [11:0] PFM_OFF_P2_1      = 12'h028; // Pin config
    localparam logic [11:0] PFM_OFF_P0_3      = 12'h02c; // Pin config
    localparam logic [11:0] PFM_OFF_BUSCLK    = 12'h030; // Bus clock pin
    localparam logic [11:0] PFM_OFF_LOC_SCK   = 12'h0b0; // Location selects
    localparam logic [11:0] PFM_OFF_LOC_DSR   = 12'h0b4;
    localparam logic [11:0] PFM_OFF_LOC_DCD   = 12'h0b8;
    localparam logic [11:0] PFM_OFF_LOC_RI    = 12'h0bc;

    // Sizes
    localparam int PFM_NPIN     = 13;  // Word slots 0x000..0x030
    localparam int PFM_NLOC     = 4;   // Location registers
    localparam int PFM_CFG_W    = 11;  // Stored config bits
    localparam int PFM_LOC_W    = 2;   // Location select width
    localparam int PFM_BUSCLK_I = 12;  // Slot index of bus clock pin
    localparam int PFM_RSVD_A_I = 1;   // Slot index of reserved slot a
    localparam int PFM_RSVD_B_I = 6;   // Slot index of reserved slot b

    // Reset values
    localparam logic [PFM_CFG_W-1:0] PFM_CFG_RST    = 11'h0d0;
    localparam logic [PFM_CFG_W-1:0] PFM_CFG_RST_BC = 11'h000;
    localparam logic [PFM_LOC_W-1:0] PFM_LOC_RST    = 2'h0;

    // Function select codes
    localparam logic [2:0] PFM_FUNCTION_SELECT_FIELD_GPIO = 3'h0;
    localparam logic [2:0] PFM_FUNCTION_SELECT_FIELD_BUS  = 3'h1; // Two-wire bus function

    // Pull mode codes
    localparam logic [1:0] PFM_PULL_NONE = 2'h0;
    localparam logic [1:0] PFM_PULL_DOWN = 2'h1;
    localparam logic [1:0] PFM_PULL_UP   = 2'h2;
    localparam logic [1:0] PFM_PULL_RPT  = 2'h3;

    // Two-wire bus pad modes
    localparam logic [1:0] PFM_BUS_STD  = 2'h0; // Filtered std/fast
    localparam logic [1:0] PFM_BUS_GPIO = 2'h1; // Plain open drain
    localparam logic [1:0] PFM_BUS_FMP  = 2'h2; // Filtered high sink

    // Stored configuration word, msb first: bits 10:0
    typedef struct packed {
        logic       spare;     // 10, kept stored, no effect
        logic [1:0] bus_mode;  // 9:8
        logic       hyst;      // 7  (1 = hysteresis)
        logic       dig_mode;  // 6  (1 = digital, 0 = analog)
        logic       od;        // 5  open_drain_bit
        logic [1:0] pull;      // 4:3
        logic [2:0] function_select_field;      // 2:0 function_select_field
    } pfm_cfg_s;

    // Decoded pad controls per pin
    typedef struct packed {
        logic       periph;    // Peripheral owns the pin
        logic       oe;        // Output enabled
        logic       hi_en;     // High-side driver enabled
        logic       pu_en;     // Pull-up on
        logic       pd_en;     // Pull-down on
        logic       hyst_en;   // Hysteresis buffer
        logic       rx_en;     // Digital receiver connected
        logic       filt_en;   // Bus glitch filter
        logic       hsink_en;  // High current sink
    } pfm_pad_s;

endpackage : pfm_pkg

/* hw/pfm_pad_dec.sv */
// Purpose: Decode one pin configuration word into pad controls
// Assumes: Purely combinational, instanced per pin
// Notes:   Analog and bus capabilities are per-pin parameters
`timescale 1ns/10ps
`default_nettype none
module pfm_pad_dec #(
    parameter bit HAS_ANALOG = 1'b0, // Pin has an analog function
    parameter bit IS_BUS_PIN = 1'b0  // Dedicated two-wire bus pin
) (
    // Configuration
    input  wire pfm_pkg::pfm_cfg_s cfg,
    // Pin state
    input  wire logic              gpio_dir,
    input  wire logic              periph_oe,
    input  wire logic              pad_level,
    input  wire logic              deep_pd,
    // Decoded controls
    output pfm_pkg::pfm_pad_s      pad
);
    // Decode per field
    always_comb begin
        logic analog;
        logic bus_fn;
        analog = HAS_ANALOG && !cfg.dig_mode;
        bus_fn = IS_BUS_PIN && cfg.function_select_field == pfm_pkg::PFM_FUNCTION_SELECT_FIELD_BUS;
        pad = '0;
        pad.periph = cfg.function_select_field != pfm_pkg::PFM_FUNCTION_SELECT_FIELD_GPIO;
        // Direction from GPIO regs only in GPIO function
        pad.oe = pad.periph ? periph_oe : gpio_dir;
        // Bus pins never drive high; od ignored there
        if (IS_BUS_PIN) begin
            pad.hi_en = 1'b0;
        end else begin
            pad.hi_en = pad.oe && !cfg.od;
        end
        pad.rx_en = !analog;
        pad.hyst_en = !analog && cfg.hyst;
        // Pulls only on digital pins
        if (!analog && !bus_fn) begin
            case (cfg.pull)
                pfm_pkg::PFM_PULL_UP:   pad.pu_en = 1'b1;
                pfm_pkg::PFM_PULL_DOWN: pad.pd_en = 1'b1;
                pfm_pkg::PFM_PULL_RPT: begin
                    // Keeper: follow level, off in deep power-down
                    pad.pu_en = pad_level && !deep_pd;
                    pad.pd_en = !pad_level && !deep_pd;
                end
                default: ;
            endcase
        end
        // Bus pad modes
        if (bus_fn) begin
            pad.filt_en  = cfg.bus_mode != pfm_pkg::PFM_BUS_GPIO;
            pad.hsink_en = cfg.bus_mode == pfm_pkg::PFM_BUS_FMP;
        end
    end
endmodule : pfm_pad_dec
`default_nettype wire

/* hw/pfm_loc_mux.sv */
// Purpose: Route one multiplexed input function from a chosen pin
// Assumes: Candidate pins given as a vector with their ownership
// Notes:   Out-of-range selects yield a quiet zero
`timescale 1ns/10ps
`default_nettype none
module pfm_loc_mux #(
    parameter int N = 4 // Candidate pins
) (
    // Selection
    input  wire logic [1:0]   sel,
    // Candidates
    input  wire logic [N-1:0] pin_in,
    input  wire logic [N-1:0] fn_sel,
    // Routed input
    output logic              fn_in,
    output logic              fn_valid
);
    initial begin
        if (N < 1 || N > 4) $error("pfm_loc_mux: N out of range");
    end
    // Pick the pin; usable only if its own config selects the function
    always_comb begin
        fn_in = 1'b0;
        fn_valid = 1'b0;
        if (int'(sel) < N) begin
            fn_valid = fn_sel[sel];
            fn_in = pin_in[sel] && fn_sel[sel];
        end
    end
endmodule : pfm_loc_mux
`default_nettype wire

/* hw/pfm_top.sv */
// Notes on behaviour
// - Function code zero means GPIO
// - GPIO direction only in GPIO function
// - Pull up, down, none or repeater; up default, none on bus clock pin
// - Repeater pulls toward current pin level
// - No repeater retention in deep power-down
// - Per-pin hysteresis or plain buffer
// - Analog mode kills receiver, hysteresis, pulls
// - Analog setting ignored on non-analog pins
// - Bus pins: filtered, fast-plus, plain open-drain
// - Open-drain bit disables high-side driver
// - Open-drain bit ignored on bus pins
// - One config register per pin
// - Location register picks routed input pin
// - Routed input needs pin config too
// - Configs reset to d0, bus clock 00
// - Offsets 004 and 018 are reserved
// - Location registers at b0..bc, reset 00
//
// Purpose: Pad function and mode configuration with APB access
// Assumes: Single clock, synchronous active-low reset, APB3 slave
// Notes:   All top outputs come from the state register; pad and routed outputs copy decoded controls
`timescale 1ns/10ps
`default_nettype none
module pfm_top #(
    parameter int NPIN = pfm_pkg::PFM_NPIN, // Config slots
    parameter logic [NPIN-1:0] ANALOG_MASK = '0, // Pins with analog
    parameter int LOC_N = 4 // Candidate pins per routed input
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Pin side inputs
    input  wire logic [NPIN-1:0]     gpio_dir,
    input  wire logic [NPIN-1:0]     periph_oe,
    input  wire logic [NPIN-1:0]     pad_level,
    input  wire logic                deep_pd,
    // Routed input candidates, one group per routed function
    input  wire logic [LOC_N-1:0]    loc_pin_in [pfm_pkg::PFM_NLOC],
    input  wire logic [LOC_N-1:0]    loc_fn_sel [pfm_pkg::PFM_NLOC],
    // Pad controls
    output pfm_pkg::pfm_pad_s [NPIN-1:0] pad_ctl,
    output logic [pfm_pkg::PFM_NLOC-1:0] loc_fn_in,
    output logic [pfm_pkg::PFM_NLOC-1:0] loc_fn_valid
);
    initial begin
        if (NPIN != pfm_pkg::PFM_NPIN) $error("pfm_top: NPIN fixed");
        if (LOC_N < 1 || LOC_N > 4) $error("pfm_top: LOC_N range");
    end

    // Whole state of the module
    typedef struct packed {
        logic [NPIN-1:0][pfm_pkg::PFM_CFG_W-1:0]          cfg;
        logic [pfm_pkg::PFM_NLOC-1:0][pfm_pkg::PFM_LOC_W-1:0] loc;
        logic [31:0]                                      rdata;
        logic                                             ready;
        logic                                             slverr;
        pfm_pkg::pfm_pad_s [NPIN-1:0]                     pad;
        logic [pfm_pkg::PFM_NLOC-1:0]                     fin;
        logic [pfm_pkg::PFM_NLOC-1:0]                     fval;
    } pfm_state_s;

    pfm_state_s st_reg;   // Registered state
    pfm_state_s st_next;  // Next state

    // Decoded, unregistered pad controls
    pfm_pkg::pfm_pad_s [NPIN-1:0] pad_dec;
    logic [pfm_pkg::PFM_NLOC-1:0] fin_dec;
    logic [pfm_pkg::PFM_NLOC-1:0] fval_dec;

    // Slot classification of an address
    function automatic logic is_rsvd(input int idx);
        return idx == pfm_pkg::PFM_RSVD_A_I || idx == pfm_pkg::PFM_RSVD_B_I;
    endfunction : is_rsvd

    // Reset value of a config slot
    function automatic logic [pfm_pkg::PFM_CFG_W-1:0] cfg_rst(
        input int idx);
        if (idx == pfm_pkg::PFM_BUSCLK_I) begin
            return pfm_pkg::PFM_CFG_RST_BC;
        end
        return pfm_pkg::PFM_CFG_RST;
    endfunction : cfg_rst

    // One decoder per pin; bus clock pin is the two-wire bus pin
    for (genvar i = 0; i < NPIN; i++) begin : g_pin
        pfm_pad_dec #(
            .HAS_ANALOG (ANALOG_MASK[i]),
            .IS_BUS_PIN (i == pfm_pkg::PFM_BUSCLK_I)
        ) u_dec (
            .cfg       (pfm_pkg::pfm_cfg_s'(st_reg.cfg[i])),
            .gpio_dir  (gpio_dir[i]),
            .periph_oe (periph_oe[i]),
            .pad_level (pad_level[i]),
            .deep_pd   (deep_pd),
            .pad       (pad_dec[i])
        );
    end

    // One router per routed input function
    for (genvar j = 0; j < pfm_pkg::PFM_NLOC; j++) begin : g_loc
        pfm_loc_mux #(
            .N (LOC_N)
        ) u_mux (
            .sel      (st_reg.loc[j]),
            .pin_in   (loc_pin_in[j]),
            .fn_sel   (loc_fn_sel[j]),
            .fn_in    (fin_dec[j]),
            .fn_valid (fval_dec[j])
        );
    end

    // Next state: APB decode and registered outputs
    always_comb begin
        int  idx;
        logic setup;
        logic hit_cfg;
        logic hit_loc;
        idx = 0;
        st_next = st_reg;
        setup = psel && !penable;
        idx = int'(paddr[11:2]);
        hit_cfg = paddr[11:2] < 10'(NPIN) && !is_rsvd(idx);
        hit_loc = paddr >= pfm_pkg::PFM_OFF_LOC_SCK &&
                  paddr <= pfm_pkg::PFM_OFF_LOC_RI;
        st_next.ready = 1'b0;
        st_next.slverr = 1'b0;
        // Answer one cycle after setup; access ends next edge
        if (setup) begin
            st_next.ready = 1'b1;
            st_next.rdata = '0;
            if (hit_cfg) begin
                if (pwrite) begin
                    st_next.cfg[idx] = pwdata[pfm_pkg::PFM_CFG_W-1:0];
                end else begin
                    st_next.rdata[pfm_pkg::PFM_CFG_W-1:0] = st_reg.cfg[idx];
                end
            end else if (hit_loc) begin
                if (pwrite) begin
                    st_next.loc[idx - int'(pfm_pkg::PFM_OFF_LOC_SCK[11:2])] =
                        pwdata[pfm_pkg::PFM_LOC_W-1:0];
                end else begin
                    st_next.rdata[pfm_pkg::PFM_LOC_W-1:0] =
                        st_reg.loc[idx - int'(pfm_pkg::PFM_OFF_LOC_SCK[11:2])];
                end
            end else begin
                // Unmapped or reserved: reads zero, error flagged only when unmapped
                st_next.slverr = !is_rsvd(idx) || paddr[11:2] >= 10'(NPIN);
            end
        end
        // Pad controls registered so outputs come from flops
        st_next.pad  = pad_dec;
        st_next.fin  = fin_dec;
        st_next.fval = fval_dec;
    end

    // State register with synchronous reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= '0;
            for (int k = 0; k < NPIN; k++) begin
                st_reg.cfg[k] <= cfg_rst(k);
            end
            for (int k = 0; k < pfm_pkg::PFM_NLOC; k++) begin
                st_reg.loc[k] <= pfm_pkg::PFM_LOC_RST;
            end
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    assign prdata       = st_reg.rdata;
    assign pready       = st_reg.ready;
    assign pslverr      = st_reg.slverr;
    assign pad_ctl      = st_reg.pad;
    assign loc_fn_in    = st_reg.fin;
    assign loc_fn_valid = st_reg.fval;

    // Assertions
    property p_reset_cfg;
        @(posedge clk) $rose(rst_n) |->
            st_reg.cfg[0] == pfm_pkg::PFM_CFG_RST &&
            st_reg.cfg[pfm_pkg::PFM_BUSCLK_I] == pfm_pkg::PFM_CFG_RST_BC;
    endproperty
    a_reset_cfg: assert property (p_reset_cfg) else $error("bad reset cfg");

    property p_gpio_dir;
        @(posedge clk) disable iff (!rst_n)
        (st_reg.cfg[0][2:0] == pfm_pkg::PFM_FUNCTION_SELECT_FIELD_GPIO) ##1
            $stable(st_reg.cfg[0]) |->
            pad_ctl[0].oe == $past(gpio_dir[0]);
    endproperty
    a_gpio_dir: assert property (p_gpio_dir) else $error("gpio dir lost");

    property p_periph;
        @(posedge clk) disable iff (!rst_n)
        (st_reg.cfg[0][2:0] != pfm_pkg::PFM_FUNCTION_SELECT_FIELD_GPIO) |=> pad_ctl[0].periph;
    endproperty
    a_periph: assert property (p_periph) else $error("periph not set");

    property p_bus_no_high;
        @(posedge clk) disable iff (!rst_n)
        !pad_ctl[pfm_pkg::PFM_BUSCLK_I].hi_en;
    endproperty
    a_bus_no_high: assert property (p_bus_no_high) else $error("bus hi");

    property p_od;
        @(posedge clk) disable iff (!rst_n)
        st_reg.cfg[0][5] && $stable(st_reg.cfg[0]) |=> !pad_ctl[0].hi_en;
    endproperty
    a_od: assert property (p_od) else $error("od ignored");

    property p_rpt_pd;
        @(posedge clk) disable iff (!rst_n)
        deep_pd && st_reg.cfg[0][4:3] == pfm_pkg::PFM_PULL_RPT |=>
            !pad_ctl[0].pu_en && !pad_ctl[0].pd_en;
    endproperty
    a_rpt_pd: assert property (p_rpt_pd) else $error("pulls clash");

    property p_rsvd;
        @(posedge clk) disable iff (!rst_n)
        psel && !penable && !pwrite && paddr == pfm_pkg::PFM_OFF_RSVD_A |=>
            pready && prdata == 32'h0000_0000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("rsvd not zero");

    property p_ready;
        @(posedge clk) disable iff (!rst_n)
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_ready: assert property (p_ready) else $error("ready timing");

    c_write: cover property (@(posedge clk) psel && penable && pwrite && pready);
    c_read:  cover property (@(posedge clk) psel && penable && !pwrite && pready);
    c_loc:   cover property (@(posedge clk) |loc_fn_valid);

endmodule : pfm_top
`default_nettype wire

/* verif/pfm_top_bench.sv */
// Purpose: Self-checking bench for the pad function and mode block
// Assumes: APB answers in the cycle after setup, pad controls one cycle late
// Notes:   Slot 2 is given an analog function through ANALOG_MASK
`timescale 1ns/10ps
`default_nettype none
module pfm_top_bench;
    localparam int          NPIN  = pfm_pkg::PFM_NPIN; // Config slots
    localparam logic [12:0] AMASK = 13'h0004;          // Analog on slot 2

    logic                         clk;          // 50 MHz clock
    logic                         rst_n;        // Sync reset
    logic                         psel;         // APB select
    logic                         penable;      // APB enable
    logic                         pwrite;       // APB direction
    logic [11:0]                  paddr;        // APB address
    logic [31:0]                  pwdata;       // APB write data
    logic [31:0]                  prdata;       // APB read data
    logic                         pready;       // APB ready
    logic                         pslverr;      // APB error
    logic [NPIN-1:0]              gpio_dir;     // GPIO directions
    logic [NPIN-1:0]              periph_oe;    // Peripheral enables
    logic [NPIN-1:0]              pad_level;    // Pin levels
    logic                         deep_pd;      // Deep power-down
    logic [3:0]                   loc_pin_in [pfm_pkg::PFM_NLOC];
    logic [3:0]                   loc_fn_sel [pfm_pkg::PFM_NLOC];
    pfm_pkg::pfm_pad_s [NPIN-1:0] pad_ctl;      // Decoded pad controls
    logic [3:0]                   loc_fn_in;    // Routed inputs
    logic [3:0]                   loc_fn_valid; // Routed usable flags
    int                           n_mismatch;   // Failed compares
    int                           checked;      // All compares

    pfm_top #(.NPIN(NPIN), .ANALOG_MASK(AMASK), .LOC_N(4)) u_pfm_top (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gpio_dir(gpio_dir), .periph_oe(periph_oe),
        .pad_level(pad_level), .deep_pd(deep_pd),
        .loc_pin_in(loc_pin_in), .loc_fn_sel(loc_fn_sel),
        .pad_ctl(pad_ctl), .loc_fn_in(loc_fn_in),
        .loc_fn_valid(loc_fn_valid));

    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Word compare
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Single bit compare
    task automatic chk1(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask : chk1

    // One APB transfer; idle edge first so strobes never change twice
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            n_mismatch++;
            $display("mismatch pready expected 1 seen none");
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Register write with expected error flag
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic ee);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        chk1("wr_err", ee, e);
    endtask : wr

    // Register read with expected data and error flag
    task automatic rd(input string nm, input logic [11:0] a,
                      input logic [31:0] x, input logic ee);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, x, r);
        chk1("rd_err", ee, e);
    endtask : rd

    // Let registered pad controls follow
    task automatic settle();
        repeat (3) @(posedge clk);
    endtask : settle

    // Config word in the local field layout
    function automatic logic [31:0] cfg(input logic [2:0] f,
            input logic [1:0] p, input logic od, input logic dg,
            input logic hy, input logic [1:0] bm);
        return {22'h0, bm, hy, dg, od, p, f};
    endfunction : cfg

    // Verdict and end of run
    task automatic test_done();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        test_done();
    end

    // Main sequence
    initial begin
        n_mismatch = 0;
        checked = 0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        gpio_dir = '0;
        periph_oe = '0;
        pad_level = '0;
        deep_pd = 1'b0;
        foreach (loc_pin_in[k]) begin
            loc_pin_in[k] = 4'h0;
            loc_fn_sel[k] = 4'h0;
        end
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, reserved slots read zero
        for (int i = 0; i < NPIN; i++) begin
            rd("cfg_rst", 12'(4*i), (i==12) ? 32'h0 : (i==1 || i==6) ?
               32'h0 : 32'hd0, 1'b0);
        end
        for (int k = 0; k < 4; k++) begin
            rd("loc_rst", 12'h0b0 + 12'(4*k), 32'h0, 1'b0);
        end
        chk1("pu_default", 1'b1, pad_ctl[0].pu_en);
        // Readback of stored bits; reserved writes ignored
        for (int i = 0; i < NPIN; i++) begin
            wr(12'(4*i), 32'hffffffff, 1'b0);
            rd("cfg_rb", 12'(4*i), (i==1 || i==6) ? 32'h0 : 32'h7ff,
               1'b0);
        end
        for (int k = 0; k < 4; k++) begin
            wr(12'h0b0 + 12'(4*k), 32'hffffffff, 1'b0);
            rd("loc_rb", 12'h0b0 + 12'(4*k), 32'h3, 1'b0);
        end
        rd("unmapped", 12'h034, 32'h0, 1'b1);
        wr(12'h0c0, 32'h1, 1'b1);
        // Function select and direction source on slot 0
        wr(12'h000, cfg(3'h0, 2'h0, 1'b0, 1'b1, 1'b1, 2'h0), 1'b0);
        gpio_dir <= 13'h0001;
        settle();
        chk1("periph", 1'b0, pad_ctl[0].periph);
        chk1("oe_gpio", 1'b1, pad_ctl[0].oe);
        chk1("hi_en", 1'b1, pad_ctl[0].hi_en);
        wr(12'h000, cfg(3'h2, 2'h0, 1'b0, 1'b1, 1'b1, 2'h0), 1'b0);
        settle();
        chk1("periph", 1'b1, pad_ctl[0].periph);
        chk1("oe_dir_ignored", 1'b0, pad_ctl[0].oe);
        gpio_dir <= 13'h0000;
        periph_oe <= 13'h0001;
        settle();
        chk1("oe_periph", 1'b1, pad_ctl[0].oe);
        wr(12'h000, cfg(3'h2, 2'h0, 1'b1, 1'b1, 1'b1, 2'h0), 1'b0);
        settle();
        chk1("hi_en_od", 1'b0, pad_ctl[0].hi_en);
        wr(12'h000, cfg(3'h0, 2'h0, 1'b1, 1'b1, 1'b1, 2'h0), 1'b0);
        gpio_dir <= 13'h1001;
        settle();
        chk1("hi_en_od_gpio", 1'b0, pad_ctl[0].hi_en);
        // Bus clock pin: open-drain bit has no say, then pad modes
        wr(12'h030, cfg(3'h0, 2'h0, 1'b0, 1'b1, 1'b1, 2'h0), 1'b0);
        settle();
        chk1("bus_hi_en", 1'b0, pad_ctl[12].hi_en);
        for (int m = 0; m < 3; m++) begin
            wr(12'h030, cfg(3'h1, 2'h0, 1'b0, 1'b1, 1'b1, 2'(m)), 1'b0);
            settle();
            chk1("filt", m != 1, pad_ctl[12].filt_en);
            chk1("hsink", m == 2, pad_ctl[12].hsink_en);
        end
        // Pull codes against pin level, hysteresis bit set equal to level
        for (int p = 0; p < 4; p++) begin
            for (int l = 0; l < 2; l++) begin
                wr(12'h000, cfg(3'h0, 2'(p), 1'b0, 1'b1, l[0], 2'h0),
                   1'b0);
                pad_level <= 13'(l);
                settle();
                chk1("pu", p==2 || (p==3 && l==1),
                     pad_ctl[0].pu_en);
                chk1("pd", p==1 || (p==3 && l==0),
                     pad_ctl[0].pd_en);
                chk1("hyst", l[0], pad_ctl[0].hyst_en);
            end
        end
        deep_pd <= 1'b1;
        settle();
        chk1("pu_deep", 1'b0, pad_ctl[0].pu_en);
        chk1("pd_deep", 1'b0, pad_ctl[0].pd_en);
        deep_pd <= 1'b0;
        // Analog mode on an analog pin and on a plain pin
        wr(12'h008, cfg(3'h0, 2'h2, 1'b0, 1'b0, 1'b1, 2'h0), 1'b0);
        wr(12'h00c, cfg(3'h0, 2'h2, 1'b0, 1'b0, 1'b1, 2'h0), 1'b0);
        settle();
        chk1("rx_an", 1'b0, pad_ctl[2].rx_en);
        chk1("hyst_an", 1'b0, pad_ctl[2].hyst_en);
        chk1("pu_an", 1'b0, pad_ctl[2].pu_en);
        chk1("rx_dig", 1'b1, pad_ctl[3].rx_en);
        chk1("pu_dig", 1'b1, pad_ctl[3].pu_en);
        // Routed inputs: every location of every function
        for (int k = 0; k < 4; k++) begin
            for (int s = 0; s < 4; s++) begin
                wr(12'h0b0 + 12'(4*k), 32'(s), 1'b0);
                loc_pin_in[k] <= 4'h1 << s;
                loc_fn_sel[k] <= 4'hf;
                settle();
                chk1("fn_in", 1'b1, loc_fn_in[k]);
                chk1("fn_valid", 1'b1, loc_fn_valid[k]);
                loc_pin_in[k] <= ~(4'h1 << s);
                loc_fn_sel[k] <= ~(4'h1 << s);
                settle();
                chk1("fn_in_lo", 1'b0, loc_fn_in[k]);
                chk1("fn_unsel", 1'b0, loc_fn_valid[k]);
            end
        end
        test_done();
    end
endmodule : pfm_top_bench
`default_nettype wire
